// File: bench/pcmux_far_pins.sv
// far-side pins: external drivers and pull-ups facing the device pads
`timescale 1ns/100ps
`default_nettype none
module pcmux_far_pins
#(
  parameter int N = 6
)
(
  input  wire logic [N-1:0] dev_out,
  input  wire logic [N-1:0] dev_oe_n,
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_val,
  output var  logic [N-1:0] level
);
  // device drive wins; a line nobody drives floats up to its pull-up
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!dev_oe_n[i])
        level[i] = dev_out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else
        level[i] = 1'b1;
    end
  end
endmodule // pcmux_far_pins
`default_nettype wire

// File: bench/pcmux_top_bench.sv
// self-checking bench for the upper third-port pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module pcmux_top_bench
  import pcmux_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata_r, rd;
  logic              pready_r, pslverr_r, err;
  wire  [PINS-1:0]   pad_in;
  wire               default_pin_in, second_port_bit3_in;
  logic [PINS-1:0]   pad_out_r, pad_oe_n_r;
  pcmux_buf_t        bit4_buf_sel_r;
  logic              sync_serial_two_wire_drive_low = 1'b0;
  logic              sync_serial_data_out = 1'b0, async_tx_data = 1'b0;
  logic              transceiver_sync_clock_out = 1'b0;
  logic              transceiver_sync_data_out = 1'b0;
  logic              second_capture_compare_out = 1'b0;
  logic              second_capture_compare_drive = 1'b0;
  logic              sync_serial_data_in_r, sync_serial_two_wire_in_r;
  logic              async_rx_data_r, transceiver_sync_clock_in_r;
  logic              transceiver_sync_data_in_r, second_capture_compare_in_r;
  logic              default_pin_out_r, default_pin_oe_n_r;
  logic              second_port_bit3_out_r, second_port_bit3_oe_n_r;
  logic [5:0]        ext_en = '0, ext_val = '0;
  int                fail_count = 0, n_tests = 0, cycles = 0;

  pcmux_top dut
  (
    .sys_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .pad_in, .pad_out_r, .pad_oe_n_r, .bit4_buf_sel_r,
    .sync_serial_two_wire_drive_low, .sync_serial_data_out,
    .sync_serial_data_in_r, .sync_serial_two_wire_in_r, .async_tx_data,
    .async_rx_data_r, .transceiver_sync_clock_out,
    .transceiver_sync_clock_in_r, .transceiver_sync_data_out,
    .transceiver_sync_data_in_r, .second_capture_compare_out,
    .second_capture_compare_drive, .default_pin_in, .second_port_bit3_in,
    .default_pin_out_r, .default_pin_oe_n_r, .second_port_bit3_out_r,
    .second_port_bit3_oe_n_r, .second_capture_compare_in_r
  );

  pcmux_far_pins #(.N(6)) far
  (
    .dev_out({second_port_bit3_out_r, default_pin_out_r, pad_out_r}),
    .dev_oe_n({second_port_bit3_oe_n_r, default_pin_oe_n_r, pad_oe_n_r}),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .level({second_port_bit3_in, default_pin_in, pad_in})
  );

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready_r !== 1'b1)
      @(posedge sys_clk);
    rd = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    check(rd, e);
    check(err, 1'b0);
  endtask

  task settle;
    repeat (3) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(OFS_DIRECTION, {RST_DIR, 4'h0});
    rdchk(OFS_LATCH, {RST_LATCH, 4'h0});
    rdchk(OFS_MUX_CTRL, RST_CTRL);
    check(pad_oe_n_r, 4'hf);
    // general-purpose drive, then sampled inputs
    wr(OFS_DIRECTION, 32'h00);
    wr(OFS_PIN_LEVELS, 32'ha0);
    apb(1'b1, 12'h010, 32'hf0);
    check(err, 1'b1);
    settle;
    check(pad_out_r, 4'ha);
    check(pad_oe_n_r, 4'h0);
    rdchk(OFS_LATCH, 32'ha0);
    rdchk(OFS_PIN_LEVELS, 32'ha0);
    wr(OFS_DIRECTION, 32'hf0);
    ext_en <= 6'h0f;
    ext_val <= 6'h05;
    settle;
    check(pad_oe_n_r, 4'hf);
    rdchk(OFS_PIN_LEVELS, 32'h50);
    rdchk(OFS_LATCH, 32'ha0);
    ext_en <= 6'h00;
    // two-wire mode on bit 4, open-drain drive
    wr(OFS_MUX_CTRL, 32'h83);
    for (int v = 0; v < 2; v++)
    begin
      sync_serial_two_wire_drive_low <= v[0];
      settle;
      check(pad_oe_n_r[P4], !v[0]);
      check(sync_serial_two_wire_in_r, !v[0]);
      check(bit4_buf_sel_r, PCMUX_BUF_I2C);
    end
    wr(OFS_MUX_CTRL, 32'h87);
    settle;
    check(bit4_buf_sel_r, PCMUX_BUF_SMBUS);
    // clocked serial: bit 4 in, bit 5 out over a latch of 1
    wr(OFS_MUX_CTRL, 32'h81);
    wr(OFS_DIRECTION, 32'hd0);
    ext_en <= 6'h01;
    for (int v = 0; v < 2; v++)
    begin
      ext_val <= {5'h0, v[0]};
      sync_serial_data_out <= v[0];
      settle;
      check(sync_serial_data_in_r, v[0]);
      check(pad_out_r[P5], v[0]);
      check(pad_oe_n_r[P5], 1'b0);
    end
    check(bit4_buf_sel_r, PCMUX_BUF_ST);
    rdchk(OFS_DIRECTION, 32'hd0);
    // asynchronous transceiver
    wr(OFS_DIRECTION, 32'hb0);
    wr(OFS_MUX_CTRL, 32'h88);
    ext_en <= 6'h08;
    for (int v = 0; v < 2; v++)
    begin
      async_tx_data <= v[0];
      ext_val <= {2'h0, !v[0], 3'h0};
      settle;
      check(pad_out_r[P6], v[0]);
      check(pad_oe_n_r[P6], 1'b0);
      check(async_rx_data_r, !v[0]);
    end
    wr(OFS_DIRECTION, 32'hf0);
    settle;
    check(pad_oe_n_r[P6], 1'b0);
    rdchk(OFS_DIRECTION, 32'hf0);
    // synchronous master transmit
    ext_en <= 6'h00;
    wr(OFS_MUX_CTRL, 32'hf8);
    for (int v = 0; v < 2; v++)
    begin
      transceiver_sync_clock_out <= v[0];
      transceiver_sync_data_out <= !v[0];
      settle;
      check(pad_out_r[P6], v[0]);
      check(pad_out_r[P7], !v[0]);
      check(pad_oe_n_r[P7], 1'b0);
    end
    // synchronous slave receive, bit 7 set up as an input first
    wr(OFS_DIRECTION, 32'hf0);
    wr(OFS_MUX_CTRL, 32'h98);
    ext_en <= 6'h0c;
    for (int v = 0; v < 2; v++)
    begin
      ext_val <= {2'h0, !v[0], v[0], 2'h0};
      settle;
      check(pad_oe_n_r[P6], 1'b1);
      check(transceiver_sync_clock_in_r, v[0]);
      check(transceiver_sync_data_in_r, !v[0]);
    end
    // capture channel routing, both settings
    ext_en <= 6'h30;
    for (int r = 1; r >= 0; r--)
    begin
      wr(OFS_MUX_CTRL, {24'h0, r[0], 7'h0});
      second_capture_compare_drive <= 1'b1;
      second_capture_compare_out <= 1'b1;
      settle;
      check(default_pin_oe_n_r, !r[0]);
      check(second_port_bit3_oe_n_r, r[0]);
      check(default_pin_out_r, r[0]);
      check(second_port_bit3_out_r, !r[0]);
      second_capture_compare_drive <= 1'b0;
      ext_val <= {!r[0], r[0], 4'h0};
      settle;
      check(second_capture_compare_in_r, 1'b1);
    end
    test_done;
  end
endmodule // pcmux_top_bench
`default_nettype wire

// File: verilog/pcmux_pin.sv
// one port pin: latch or peripheral drive, registered pad controls
`timescale 1ns/100ps
`default_nettype none
module pcmux_pin
  import pcmux_pkg::*;
(
  sys_clk,
  srst,
  dir_bit,
  lat_bit,
  periph_own,
  periph_drive,
  periph_val,
  pad_out_r,
  pad_oe_n_r
);
  input  wire logic sys_clk;
  input  wire logic srst;
  input  wire logic dir_bit;
  input  wire logic lat_bit;
  input  wire logic periph_own;
  input  wire logic periph_drive;
  input  wire logic periph_val;
  output var  logic pad_out_r;
  output var  logic pad_oe_n_r;

  logic pad_out_nxt;
  logic pad_oe_n_nxt;

  always_comb
  begin
    if (periph_own)
    begin
      // peripheral decides direction, stored bit ignored
      pad_oe_n_nxt = ~periph_drive;
      pad_out_nxt  = periph_drive & periph_val;
    end
    else
    begin
      pad_oe_n_nxt = dir_bit;
      pad_out_nxt  = lat_bit;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pad_out_r  <= RST_PAD_OUT;
      pad_oe_n_r <= RST_OE_N;
    end
    else
    begin
      pad_out_r  <= pad_out_nxt;
      pad_oe_n_r <= pad_oe_n_nxt;
    end
  end

endmodule // pcmux_pin
`default_nettype wire

// File: verilog/pcmux_pkg.sv
// constants and types for the upper third-port pin multiplexer
`default_nettype none
package pcmux_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [11:0] OFS_PIN_LEVELS = 12'h000;
  localparam logic [11:0] OFS_LATCH      = 12'h004;
  localparam logic [11:0] OFS_DIRECTION  = 12'h008;
  localparam logic [11:0] OFS_MUX_CTRL   = 12'h00c;

  // this block implements port bits 7 down to 4
  localparam int unsigned PINS      = 4;
  localparam int unsigned UPPER_MSB = 7;
  localparam int unsigned UPPER_LSB = 4;
  localparam int unsigned P4        = 0;
  localparam int unsigned P5        = 1;
  localparam int unsigned P6        = 2;
  localparam int unsigned P7        = 3;

  // reset values: pins come up as inputs, routing bit set
  localparam logic [3:0]  RST_LATCH   = 4'h0;
  localparam logic [3:0]  RST_DIR     = 4'hf;
  localparam logic [7:0]  RST_CTRL    = 8'h80;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
  localparam logic        RST_OE_N    = 1'b1;
  localparam logic        RST_PAD_OUT = 1'b0;

  // mux control register fields
  localparam int unsigned CTL_SSP_EN    = 0;
  localparam int unsigned CTL_TWO_WIRE  = 1;
  localparam int unsigned CTL_SMBUS     = 2;
  localparam int unsigned CTL_TCV_EN    = 3;
  localparam int unsigned CTL_TCV_SYNC  = 4;
  localparam int unsigned CTL_TCV_MASTR = 5;
  localparam int unsigned CTL_TCV_TXDIR = 6;
  localparam int unsigned CTL_CC2_ROUTE = 7;

  // input buffer type selected for bit 4
  typedef enum logic [1:0] {
    PCMUX_BUF_ST,
    PCMUX_BUF_I2C,
    PCMUX_BUF_SMBUS
  } pcmux_buf_t;

endpackage
`default_nettype wire

// File: verilog/pcmux_top.sv
// upper third-port pin multiplexer with apb register slave
`timescale 1ns/100ps
`default_nettype none
module pcmux_top
  import pcmux_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata_r,
  output var  logic              pready_r,
  output var  logic              pslverr_r,
  input  wire logic [PINS-1:0]   pad_in,
  output var  logic [PINS-1:0]   pad_out_r,
  output var  logic [PINS-1:0]   pad_oe_n_r,
  output var  pcmux_buf_t        bit4_buf_sel_r,
  input  wire logic              sync_serial_two_wire_drive_low,
  input  wire logic              sync_serial_data_out,
  output var  logic              sync_serial_data_in_r,
  output var  logic              sync_serial_two_wire_in_r,
  input  wire logic              async_tx_data,
  output var  logic              async_rx_data_r,
  input  wire logic              transceiver_sync_clock_out,
  output var  logic              transceiver_sync_clock_in_r,
  input  wire logic              transceiver_sync_data_out,
  output var  logic              transceiver_sync_data_in_r,
  input  wire logic              second_capture_compare_out,
  input  wire logic              second_capture_compare_drive,
  input  wire logic              default_pin_in,
  input  wire logic              second_port_bit3_in,
  output var  logic              default_pin_out_r,
  output var  logic              default_pin_oe_n_r,
  output var  logic              second_port_bit3_out_r,
  output var  logic              second_port_bit3_oe_n_r,
  output var  logic              second_capture_compare_in_r
);

  //////////////////////////////////////////////////////////////////////////
  // registers and apb decode

  logic [PINS-1:0] latch_r;
  logic [PINS-1:0] dir_r;
  logic [7:0]      ctrl_r;
  logic [PINS-1:0] pin_level_r;

  logic              setup;
  logic              wr_acc;
  logic              addr_hit;
  logic [DATA_W-1:0] rdata_nxt;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;

  always_comb
  begin
    addr_hit  = 1'b1;
    rdata_nxt = RST_RDATA;
    case (paddr)
      OFS_PIN_LEVELS: rdata_nxt[UPPER_MSB:UPPER_LSB] = pin_level_r;
      OFS_LATCH:      rdata_nxt[UPPER_MSB:UPPER_LSB] = latch_r;
      OFS_DIRECTION:  rdata_nxt[UPPER_MSB:UPPER_LSB] = dir_r;
      OFS_MUX_CTRL:   rdata_nxt[7:0] = ctrl_r;
      default:        addr_hit = 1'b0;
    endcase
  end

  // zero-wait answer: ready rises in the first access cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pready_r <= 1'b0;
    else
      pready_r <= setup;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pslverr_r <= 1'b0;
    else
      pslverr_r <= setup & ~addr_hit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      prdata_r <= RST_RDATA;
    else if (setup & ~pwrite)
      prdata_r <= rdata_nxt;
    else if (setup)
      prdata_r <= RST_RDATA;
  end

  // both pin-level and latch addresses write the latch
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      latch_r <= RST_LATCH;
    else if (wr_acc && (paddr == OFS_LATCH || paddr == OFS_PIN_LEVELS))
      latch_r <= pwdata[UPPER_MSB:UPPER_LSB];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      dir_r <= RST_DIR;
    else if (wr_acc && paddr == OFS_DIRECTION)
      dir_r <= pwdata[UPPER_MSB:UPPER_LSB];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctrl_r <= RST_CTRL;
    else if (wr_acc && paddr == OFS_MUX_CTRL)
      ctrl_r <= pwdata[7:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pin_level_r <= RST_LATCH;
    else
      pin_level_r <= pad_in;
  end

  //////////////////////////////////////////////////////////////////////////
  // mode decode and per-pin ownership

  logic ssp_on;
  logic two_wire;
  logic clk_serial;
  logic tcv_async;
  logic tcv_sync;
  logic sync_master;
  logic sync_slave;
  logic sync_tx;
  logic two_wire_own;
  logic [PINS-1:0] own;
  logic [PINS-1:0] drive;
  logic [PINS-1:0] val;

  assign ssp_on      = ctrl_r[CTL_SSP_EN];
  assign two_wire    = ssp_on & ctrl_r[CTL_TWO_WIRE];
  assign clk_serial  = ssp_on & ~ctrl_r[CTL_TWO_WIRE];
  assign tcv_async   = ctrl_r[CTL_TCV_EN] & ~ctrl_r[CTL_TCV_SYNC];
  assign tcv_sync    = ctrl_r[CTL_TCV_EN] & ctrl_r[CTL_TCV_SYNC];
  assign sync_master = tcv_sync & ctrl_r[CTL_TCV_MASTR];
  assign sync_slave  = tcv_sync & ~ctrl_r[CTL_TCV_MASTR];
  assign sync_tx     = tcv_sync & ctrl_r[CTL_TCV_TXDIR];
  assign two_wire_own = two_wire & dir_r[P4];

  always_comb
  begin
    // bit 4: open-drain data line or clocked serial input
    own[P4]   = (two_wire | clk_serial) & dir_r[P4];
    drive[P4] = two_wire_own & sync_serial_two_wire_drive_low;
    val[P4]   = 1'b0;
    // bit 5: clocked serial data out when direction is output
    own[P5]   = clk_serial & ~dir_r[P5];
    drive[P5] = clk_serial & ~dir_r[P5];
    val[P5]   = sync_serial_data_out;
    // bit 6: transmit data, generated clock or incoming clock
    own[P6]   = tcv_async | tcv_sync;
    drive[P6] = tcv_async | sync_master;
    val[P6]   = tcv_async ? async_tx_data : transceiver_sync_clock_out;
    // bit 7: receive input or sync data in either direction
    own[P7]   = tcv_async | tcv_sync;
    drive[P7] = sync_tx;
    val[P7]   = transceiver_sync_data_out;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1)
    begin : g_pin
      pcmux_pin u_pin (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .dir_bit      (dir_r[gi]),
        .lat_bit      (latch_r[gi]),
        .periph_own   (own[gi]),
        .periph_drive (drive[gi]),
        .periph_val   (val[gi]),
        .pad_out_r    (pad_out_r[gi]),
        .pad_oe_n_r   (pad_oe_n_r[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // input buffers and peripheral inputs

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bit4_buf_sel_r <= PCMUX_BUF_ST;
    else if (two_wire_own)
      bit4_buf_sel_r <= ctrl_r[CTL_SMBUS] ? PCMUX_BUF_SMBUS
                                          : PCMUX_BUF_I2C;
    else
      bit4_buf_sel_r <= PCMUX_BUF_ST;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync_serial_data_in_r     <= 1'b0;
      sync_serial_two_wire_in_r <= 1'b1;
    end
    else
    begin
      sync_serial_data_in_r <= clk_serial & dir_r[P4] & pad_in[P4];
      sync_serial_two_wire_in_r <= ~two_wire_own | pad_in[P4];
    end
  end

  // transceiver inputs idle high when not routed
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      async_rx_data_r             <= 1'b1;
      transceiver_sync_clock_in_r <= 1'b1;
      transceiver_sync_data_in_r  <= 1'b1;
    end
    else
    begin
      async_rx_data_r             <= ~tcv_async | pad_in[P7];
      transceiver_sync_clock_in_r <= ~sync_slave | pad_in[P6];
      transceiver_sync_data_in_r  <= ~tcv_sync | pad_in[P7];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // second capture/compare pin routing

  logic cc2_route;
  assign cc2_route = ctrl_r[CTL_CC2_ROUTE];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      default_pin_out_r           <= RST_PAD_OUT;
      default_pin_oe_n_r          <= RST_OE_N;
      second_port_bit3_out_r      <= RST_PAD_OUT;
      second_port_bit3_oe_n_r     <= RST_OE_N;
      second_capture_compare_in_r <= 1'b0;
    end
    else
    begin
      default_pin_out_r <= cc2_route & second_capture_compare_out;
      default_pin_oe_n_r <= ~(cc2_route & second_capture_compare_drive);
      second_port_bit3_out_r <= ~cc2_route & second_capture_compare_out;
      second_port_bit3_oe_n_r <=
        ~(~cc2_route & second_capture_compare_drive);
      second_capture_compare_in_r <=
        cc2_route ? default_pin_in : second_port_bit3_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_two_wire_drive;
    two_wire_own & sync_serial_two_wire_drive_low
      |=> !pad_oe_n_r[P4] && !pad_out_r[P4];
  endproperty
  a_two_wire_drive: assert property (p_two_wire_drive)
    else $error("bit4 not pulled low by two-wire unit");
  property p_two_wire_buf;
    two_wire_own |=> bit4_buf_sel_r ==
      ($past(ctrl_r[CTL_SMBUS]) ? PCMUX_BUF_SMBUS : PCMUX_BUF_I2C);
  endproperty
  a_two_wire_buf: assert property (p_two_wire_buf)
    else $error("bit4 buffer type does not follow unit mode");
  property p_clk_serial_in;
    clk_serial & dir_r[P4] |=> pad_oe_n_r[P4]
      && bit4_buf_sel_r == PCMUX_BUF_ST
      && sync_serial_data_in_r == $past(pad_in[P4]);
  endproperty
  a_clk_serial_in: assert property (p_clk_serial_in)
    else $error("bit4 not routed to serial data input");
  property p_clk_serial_out;
    clk_serial & ~dir_r[P5] |=> !pad_oe_n_r[P5]
      && pad_out_r[P5] == $past(sync_serial_data_out);
  endproperty
  a_clk_serial_out: assert property (p_clk_serial_out)
    else $error("bit5 not driven with serial data out");
  property p_async_tx;
    tcv_async |=> !pad_oe_n_r[P6] && pad_out_r[P6] == $past(async_tx_data);
  endproperty
  a_async_tx: assert property (p_async_tx)
    else $error("bit6 not driven with transmit data");
  property p_sync_master_clk;
    sync_master |=> !pad_oe_n_r[P6]
      && pad_out_r[P6] == $past(transceiver_sync_clock_out);
  endproperty
  a_sync_master_clk: assert property (p_sync_master_clk)
    else $error("bit6 not driven with serial clock");
  property p_sync_slave_clk;
    sync_slave |=> pad_oe_n_r[P6]
      && transceiver_sync_clock_in_r == $past(pad_in[P6]);
  endproperty
  a_sync_slave_clk: assert property (p_sync_slave_clk)
    else $error("bit6 clock not fed to transceiver");
  property p_async_rx;
    tcv_async |=> pad_oe_n_r[P7] && async_rx_data_r == $past(pad_in[P7]);
  endproperty
  a_async_rx: assert property (p_async_rx)
    else $error("bit7 not routed to receiver");
  property p_sync_tx;
    sync_tx |=> !pad_oe_n_r[P7]
      && pad_out_r[P7] == $past(transceiver_sync_data_out);
  endproperty
  a_sync_tx: assert property (p_sync_tx)
    else $error("bit7 not driven with sync data");
  property p_cc2_route;
    !cc2_route |=> default_pin_oe_n_r
      && second_capture_compare_in_r == $past(second_port_bit3_in);
  endproperty
  a_cc2_route: assert property (p_cc2_route)
    else $error("capture channel not on alternate pin");
  property p_gpio;
    ~own[P5] |=> pad_oe_n_r[P5] == $past(dir_r[P5])
      && (pad_oe_n_r[P5] || pad_out_r[P5] == $past(latch_r[P5]));
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("bit5 general-purpose drive mismatch");
  property p_dir_read;
    setup & ~pwrite & (paddr == OFS_DIRECTION)
      |=> prdata_r[UPPER_MSB:UPPER_LSB] == $past(dir_r) && pready_r;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read does not return stored bits");
  c_two_wire: cover property (two_wire_own ##1 !pad_oe_n_r[P4]);
  c_async:    cover property (tcv_async ##1 !pad_oe_n_r[P6]);
  c_sync_tx:  cover property (sync_tx ##1 !pad_oe_n_r[P7]);
  c_apb_wr:   cover property (wr_acc && paddr == OFS_DIRECTION);

endmodule // pcmux_top
`default_nettype wire
